// ---- cpsc_pkg.sv ----
// Purpose: Shared constants for the pipeline and stack control block
// Assumes: APB register window, 32-bit data, one aligned word per register
// Notes:   Behaviour
// Behaviour
// RULE_01 - Stack error with option on: flag, then reset
// RULE_02 - Stack error with option off: flag only; an underflow pop here also loads the PC with PC_RESET
// RULE_03 - Stack flags cleared only by software or POR
// RULE_04 - One-entry shadow store, invisible to software
// RULE_05 - Any interrupt vector captures status, working, bank
// RULE_06 - Fast interrupt return restores shadow values
// RULE_07 - High-priority interrupt overwrites low-priority shadow
// RULE_08 - Fast call saves registers to shadow store
// RULE_09 - Fast return restores registers from shadow
// RULE_10 - Software uses even computed-jump offsets
// RULE_11 - Table read latches one program byte
// RULE_12 - Clock divided into four phases Q1-Q4
// RULE_13 - Fetch: PC increments Q1, word captured Q4
// RULE_14 - Execute: IR loads Q1, execute Q2-Q4
// RULE_15 - Operand read Q2, destination write Q4
// RULE_16 - Fetch overlaps execute, one cycle throughput
// RULE_17 - PC change discards prefetched word, two cycles
// RULE_18 - PC low write loads upper bits from latches
// RULE_19 - PC bit 0 held zero, step of two
// RULE_20 - Full flag bit 7, underflow bit 6
// RULE_21 - Phase generator restarts at Q1 after reset
package cpsc_pkg;

  localparam int          PC_W            = 21;
  localparam int          SP_W            = 5;
  localparam int          ADDR_W          = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0]  OFF_CONFIG      = 8'h00;
  localparam logic [7:0]  OFF_STACK       = 8'h04;
  localparam logic [7:0]  OFF_PC_LATCH    = 8'h08;
  localparam logic [7:0]  OFF_TBL_PTR     = 8'h0C;
  localparam logic [7:0]  OFF_TBL_LATCH   = 8'h10;
  localparam logic [7:0]  OFF_PC          = 8'h14;
  localparam logic [7:0]  OFF_IR          = 8'h18;

  // ==========================================================
  // Field positions and reset values
  localparam int          CFG_SERE_BIT    = 0;
  localparam int          STK_FULL_BIT    = 7;
  localparam int          STK_UNF_BIT     = 6;
  localparam int          LATCH_UPPER_LSB = 8;
  localparam logic        CFG_SERE_RESET  = 1'b1;
  localparam logic [20:0] PC_RESET        = 21'h0_0000;
  localparam logic [20:0] PC_STEP         = 21'h0_0002;
  localparam logic [4:0]  SP_RESET        = 5'h00;
  localparam logic [4:0]  SP_MAX          = 5'h1F;
  localparam logic [4:0]  SP_ONE          = 5'h01;

  // ==========================================================
  // Flow operations reported by the execute unit
  typedef logic [3:0] cpsc_op_t;
  localparam cpsc_op_t OP_NONE        = 4'h0;
  localparam cpsc_op_t OP_BRANCH      = 4'h1;
  localparam cpsc_op_t OP_CALL        = 4'h2;
  localparam cpsc_op_t OP_CALL_FAST   = 4'h3;
  localparam cpsc_op_t OP_RETURN      = 4'h4;
  localparam cpsc_op_t OP_RETURN_FAST = 4'h5;
  localparam cpsc_op_t OP_RETURN_FROM_INTERRUPT      = 4'h6;
  localparam cpsc_op_t OP_RETURN_FROM_INTERRUPT_FAST = 4'h7;
  localparam cpsc_op_t OP_WRITE_PCL   = 4'h8;
  localparam cpsc_op_t OP_TABLE_READ  = 4'h9;

  // ==========================================================
  // Instruction-cycle phases
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } cpsc_phase_e;

endpackage : cpsc_pkg

// ---- cpsc_phase_gen.sv ----
// Purpose: Divide-by-four phase ring for the instruction cycle
// Assumes: One clock, restart is a one-cycle pulse
// Notes:   Restart wins over rotation
`timescale 1ns/10ps
module cpsc_phase_gen
  import cpsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        restart,
  output cpsc_phase_e      phase
);

  cpsc_phase_e phase_reg;
  cpsc_phase_e phase_next;

  // ==========================================================
  // Ring
  always_comb begin
    unique case (phase_reg)
      PH_Q1:   phase_next = PH_Q2;
      PH_Q2:   phase_next = PH_Q3;
      PH_Q3:   phase_next = PH_Q4;
      PH_Q4:   phase_next = PH_Q1;
      default: phase_next = PH_Q1;
    endcase
    if (restart) begin
      phase_next = PH_Q1; // [RULE_21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_Q1; // [RULE_12]
    end else begin
      phase_reg <= phase_next; // [RULE_12]
    end
  end

  assign phase = phase_reg;

  chk_phase_ring: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
    (phase_reg == PH_Q1 && !restart) |=> (phase_reg == PH_Q2))
    else $error("phase ring did not advance");

  chk_phase_restart: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_21]
    restart |=> phase_reg == PH_Q1)
    else $error("phase did not restart at Q1");

endmodule : cpsc_phase_gen

// ---- cpsc_core.sv ----
// Purpose: Fetch/execute pipeline, stack flags and shadow store control
// Assumes: Execute unit reports flow ops and interrupts during Q4
// Notes:   Registers on APB, zero wait states, unmapped gives pslverr
`timescale 1ns/10ps
module cpsc_core
  import cpsc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic [PC_W-1:0]        pm_addr,
  input  wire logic [15:0]       pm_rdata,
  output logic [15:0]            instruction_holding_register,
  output logic                   ir_valid,
  output logic [3:0]             phase_q,
  output logic                   dm_rd_strobe,
  output logic                   dm_wr_strobe,
  input  wire logic              op_valid,
  input  wire logic [3:0]        op_code,
  input  wire logic [PC_W-1:0]   op_target,
  input  wire logic [7:0]        op_data,
  input  wire logic              irq_take,
  input  wire logic [PC_W-1:0]   irq_vector,
  input  wire logic [7:0]        core_status,
  input  wire logic [7:0]        core_working_register,
  input  wire logic [3:0]        core_bank_select_register,
  output logic                   restore_en,
  output logic [7:0]             restore_status,
  output logic [7:0]             restore_working_register,
  output logic [3:0]             restore_bank_select_register,
  output logic                   device_reset
);

  // ==========================================================
  // State
  cpsc_phase_e      phase;
  logic [PC_W-1:0]  pc_reg,        pc_next;
  logic [PC_W-1:0]  pm_addr_reg,   pm_addr_next;
  logic [15:0]      fetch_reg,     fetch_next;
  logic             fvalid_reg,    fvalid_next;
  logic [15:0]      ir_reg,        ir_next;
  logic             irv_reg,       irv_next;
  logic             tpend_reg,     tpend_next;
  logic             tact_reg,      tact_next;
  logic [PC_W-1:0]  tptr_reg,      tptr_next;
  logic [7:0]       tlat_reg,      tlat_next;
  logic [4:0]       sp_reg,        sp_next;
  logic             full_reg,      full_next;
  logic             unf_reg,       unf_next;
  logic             sere_reg,      sere_next;
  logic [7:0]       lath_reg,      lath_next;
  logic [4:0]       latu_reg,      latu_next;
  logic [19:0]      shadow_reg,    shadow_next;
  logic             rest_reg,      rest_next;
  logic             drst_reg,      drst_next;
  logic             q4_go, op_go, do_push, do_pop, stk_err;
  logic             wr_acc, rd_setup, mapped;
  logic [31:0]      rdata_reg,     rdata_next;

  cpsc_phase_gen u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (drst_reg),
    .phase   (phase)
  );

  assign q4_go  = (phase == PH_Q4) && !drst_reg;
  assign op_go  = q4_go && !irq_take && op_valid && irv_reg;
  assign wr_acc = psel && penable && pwrite;

  // ==========================================================
  // Pipeline, stack and register writes
  always_comb begin
    pc_next      = pc_reg;
    pm_addr_next = pm_addr_reg;
    fetch_next   = fetch_reg;
    fvalid_next  = fvalid_reg;
    ir_next      = ir_reg;
    irv_next     = irv_reg;
    tpend_next   = tpend_reg;
    tact_next    = tact_reg;
    tptr_next    = tptr_reg;
    tlat_next    = tlat_reg;
    sp_next      = sp_reg;
    full_next    = full_reg;
    unf_next     = unf_reg;
    sere_next    = sere_reg;
    lath_next    = lath_reg;
    latu_next    = latu_reg;
    shadow_next  = shadow_reg;
    rest_next    = 1'b0;
    drst_next    = 1'b0;
    do_push      = 1'b0;
    do_pop       = 1'b0;
    stk_err      = 1'b0;
    // Software writes first so that hardware events below win
    if (wr_acc) begin
      unique case (paddr)
        OFF_CONFIG:   sere_next = pwdata[CFG_SERE_BIT];
        OFF_STACK: begin
          sp_next = pwdata[4:0];
          if (!pwdata[STK_FULL_BIT]) full_next = 1'b0; // [RULE_03] [RULE_20]
          if (!pwdata[STK_UNF_BIT])  unf_next  = 1'b0; // [RULE_03] [RULE_20]
        end
        OFF_PC_LATCH: begin
          lath_next = pwdata[7:0];
          latu_next = pwdata[LATCH_UPPER_LSB +: 5];
        end
        OFF_TBL_PTR:  tptr_next = pwdata[PC_W-1:0];
        default:      ;
      endcase
    end
    if (drst_reg) begin
      // Device reset: flags, config and latches survive it
      pc_next      = PC_RESET;
      pm_addr_next = PC_RESET;
      sp_next      = SP_RESET;
      fvalid_next  = 1'b0;
      irv_next     = 1'b0;
      tpend_next   = 1'b0;
      tact_next    = 1'b0;
    end else if (phase == PH_Q1) begin
      if (tpend_reg) begin
        // Table cycle borrows the fetch slot; execute gets a bubble
        pm_addr_next = {tptr_reg[PC_W-1:1], 1'b0};
        irv_next     = 1'b0;
        tact_next    = 1'b1;
        tpend_next   = 1'b0;
      end else begin
        pm_addr_next = pc_reg;
        pc_next      = pc_reg + PC_STEP; // [RULE_13] [RULE_19]
        ir_next      = fetch_reg; // [RULE_14]
        irv_next     = fvalid_reg; // [RULE_16]
        tact_next    = 1'b0;
      end
    end else if (phase == PH_Q4) begin
      if (tact_reg) begin
        tlat_next = tptr_reg[0] ? pm_rdata[15:8] : pm_rdata[7:0]; // [RULE_11]
        tact_next = 1'b0;
      end else begin
        fetch_next  = pm_rdata; // [RULE_13]
        fvalid_next = 1'b1;
      end
      if (irq_take) begin
        do_push     = 1'b1;
        shadow_next = {core_status, core_working_register,
                       core_bank_select_register}; // [RULE_05] [RULE_07]
        pc_next     = {irq_vector[PC_W-1:1], 1'b0};
        fvalid_next = 1'b0; // [RULE_17]
      end else if (op_go) begin
        unique case (op_code)
          OP_BRANCH: begin
            pc_next     = {op_target[PC_W-1:1], 1'b0};
            fvalid_next = 1'b0; // [RULE_17]
          end
          OP_CALL, OP_CALL_FAST: begin
            do_push     = 1'b1;
            pc_next     = {op_target[PC_W-1:1], 1'b0};
            fvalid_next = 1'b0; // [RULE_17]
            if (op_code == OP_CALL_FAST) begin
              shadow_next = {core_status, core_working_register,
                             core_bank_select_register}; // [RULE_08]
            end
          end
          OP_RETURN, OP_RETURN_FAST, OP_RETURN_FROM_INTERRUPT, OP_RETURN_FROM_INTERRUPT_FAST: begin
            do_pop      = 1'b1;
            pc_next     = {op_target[PC_W-1:1], 1'b0};
            fvalid_next = 1'b0; // [RULE_17]
            rest_next   = (op_code == OP_RETURN_FAST) ||
                          (op_code == OP_RETURN_FROM_INTERRUPT_FAST); // [RULE_06] [RULE_09]
          end
          OP_WRITE_PCL: begin
            // Computed jump relies on software keeping the offset even
            pc_next     = {latu_reg, lath_reg, op_data[7:1], 1'b0}; // [RULE_18] [RULE_10]
            fvalid_next = 1'b0; // [RULE_17]
          end
          OP_TABLE_READ: tpend_next = 1'b1; // [RULE_11]
          default:       ;
        endcase
      end
    end
    if (do_push) begin
      if (sp_reg == SP_MAX) begin
        full_next = 1'b1; // [RULE_20]
        stk_err   = 1'b1;
      end else begin
        sp_next = sp_reg + SP_ONE;
        if (sp_reg == SP_MAX - SP_ONE) begin
          full_next = 1'b1; // [RULE_01] [RULE_02]
          stk_err   = 1'b1;
        end
      end
    end
    if (do_pop) begin
      if (sp_reg == SP_RESET) begin
        unf_next = 1'b1; // [RULE_01] [RULE_02]
        stk_err  = 1'b1;
        pc_next  = PC_RESET;
      end else begin
        sp_next = sp_reg - SP_ONE;
      end
    end
    drst_next = stk_err && sere_reg; // [RULE_01] [RULE_02]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg      <= PC_RESET;
      pm_addr_reg <= PC_RESET;
      fetch_reg   <= 16'h0000;
      fvalid_reg  <= 1'b0;
      ir_reg      <= 16'h0000;
      irv_reg     <= 1'b0;
      tpend_reg   <= 1'b0;
      tact_reg    <= 1'b0;
      tptr_reg    <= PC_RESET;
      tlat_reg    <= 8'h00;
      sp_reg      <= SP_RESET;
      full_reg    <= 1'b0;
      unf_reg     <= 1'b0;
      sere_reg    <= CFG_SERE_RESET;
      lath_reg    <= 8'h00;
      latu_reg    <= 5'h00;
      shadow_reg  <= 20'h0_0000;
      rest_reg    <= 1'b0;
      drst_reg    <= 1'b0;
    end else begin
      pc_reg      <= pc_next;
      pm_addr_reg <= pm_addr_next;
      fetch_reg   <= fetch_next;
      fvalid_reg  <= fvalid_next;
      ir_reg      <= ir_next;
      irv_reg     <= irv_next;
      tpend_reg   <= tpend_next;
      tact_reg    <= tact_next;
      tptr_reg    <= tptr_next;
      tlat_reg    <= tlat_next;
      sp_reg      <= sp_next;
      full_reg    <= full_next;
      unf_reg     <= unf_next;
      sere_reg    <= sere_next;
      lath_reg    <= lath_next;
      latu_reg    <= latu_next;
      shadow_reg  <= shadow_next; // [RULE_04]
      rest_reg    <= rest_next;
      drst_reg    <= drst_next;
    end
  end

  // ==========================================================
  // APB read path, data registered in the setup cycle
  assign rd_setup = psel && !penable && !pwrite;
  always_comb begin
    mapped     = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      OFF_CONFIG:    rdata_next[CFG_SERE_BIT] = sere_reg;
      OFF_STACK: begin
        rdata_next[STK_FULL_BIT] = full_reg; // [RULE_20]
        rdata_next[STK_UNF_BIT]  = unf_reg; // [RULE_20]
        rdata_next[4:0]          = sp_reg;
      end
      OFF_PC_LATCH:  rdata_next[12:0]  = {latu_reg, lath_reg};
      OFF_TBL_PTR:   rdata_next[20:0]  = tptr_reg;
      OFF_TBL_LATCH: rdata_next[7:0]   = tlat_reg;
      OFF_PC:        rdata_next[20:0]  = pc_reg;
      OFF_IR:        rdata_next[15:0]  = ir_reg;
      default:       mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_reg <= rdata_next;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_reg;

  // ==========================================================
  // Outputs
  assign pm_addr                      = pm_addr_reg;
  assign instruction_holding_register = ir_reg;
  assign ir_valid                     = irv_reg;
  assign phase_q                      = phase;
  assign dm_rd_strobe = irv_reg && (phase == PH_Q2); // [RULE_15]
  assign dm_wr_strobe = irv_reg && (phase == PH_Q4); // [RULE_15]
  assign restore_en                   = rest_reg;
  assign restore_status               = shadow_reg[19:12];
  assign restore_working_register     = shadow_reg[11:4];
  assign restore_bank_select_register = shadow_reg[3:0];
  assign device_reset                 = drst_reg;

  // ==========================================================
  // Checks
  chk_pc_even: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    pc_reg[0] == 1'b0 && pm_addr_reg[0] == 1'b0)
    else $error("program counter bit 0 not zero");

  chk_fetch_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
    (phase == PH_Q1 && !drst_reg && !tpend_reg) |=>
      pc_reg == $past(pc_reg) + PC_STEP && pm_addr_reg == $past(pc_reg))
    else $error("fetch did not step by two");

  chk_flush_bubble: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
    (op_go && op_code == OP_BRANCH) |=> !fvalid_reg ##1 !irv_reg[*4])
    else $error("prefetched word not discarded");

  chk_stack_reset: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    (stk_err && sere_reg) |=> (full_reg || unf_reg) && drst_reg
      ##1 sp_reg == SP_RESET && phase == PH_Q1)
    else $error("stack error did not reset device");

  chk_no_reset: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    (stk_err && !sere_reg) |=> !drst_reg && (full_reg || unf_reg))
    else $error("stack error reset while option off");

  chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    (full_reg && !(wr_acc && paddr == OFF_STACK)) |=> full_reg)
    else $error("full flag lost without software clear");

  chk_shadow_save: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    (q4_go && irq_take) |=> restore_status == $past(core_status) &&
      restore_bank_select_register == $past(core_bank_select_register))
    else $error("shadow not captured on interrupt");

  chk_fast_restore: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    (op_go && op_code == OP_RETURN_FROM_INTERRUPT_FAST) |=> restore_en &&
      $stable(shadow_reg) ##1 !restore_en)
    else $error("fast return did not restore");

  chk_table_byte: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
    (phase == PH_Q4 && tact_reg && !drst_reg) |=> tlat_reg ==
      ($past(tptr_reg[0]) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])))
    else $error("table latch byte wrong");

  chk_dm_phase: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    dm_rd_strobe |=> ##1 dm_wr_strobe || !irv_reg)
    else $error("data write not two phases after read");

  cov_call_fast: cover property (@(posedge pclk) disable iff (!presetn)
    op_go && op_code == OP_CALL_FAST);
  cov_irq_take: cover property (@(posedge pclk) disable iff (!presetn)
    q4_go && irq_take);
  cov_underflow: cover property (@(posedge pclk) disable iff (!presetn)
    do_pop && sp_reg == SP_RESET);
  cov_table: cover property (@(posedge pclk) disable iff (!presetn)
    tact_reg && phase == PH_Q4);

endmodule : cpsc_core

// ---- cpsc_far_model.sv ----
// Purpose: Program memory and interrupt source facing the core
// Assumes: The word at byte address a is {a[8:1], ~a[8:1]}
// Notes:   Combinational reply; interrupt offered only in a Q4 cycle
`timescale 1ns/10ps
module cpsc_far_model
  import cpsc_pkg::*;
#(
  parameter logic [PC_W-1:0] VEC = 21'h0_0008
)(
  input  wire logic [PC_W-1:0] pm_addr,
  output logic      [15:0]     pm_rdata,
  input  wire logic [3:0]      phase_q,
  input  wire logic            irq_req,
  output logic                 irq_take,
  output logic      [PC_W-1:0] irq_vector
);
  // ==========================================================
  // Replies
  // Address-derived words let the bench predict every fetch
  assign pm_rdata   = {pm_addr[8:1], ~pm_addr[8:1]};
  assign irq_take   = irq_req & phase_q[3];
  assign irq_vector = VEC;
endmodule : cpsc_far_model

// ---- tb_cpu_pipeline_stack_control.sv ----
// Purpose: Self-checking bench for the pipeline and stack control core
// Assumes: APB slave answers when pready is high; ops offered in Q4
// Notes:   Phase, strobe and fetch outputs are observed at the falling edge, mid-cycle
`timescale 1ns/10ps
module tb_cpu_pipeline_stack_control
  import cpsc_pkg::*;
;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic              pwrite = 0, op_valid = 0, irq_req = 0, err, dr_prev;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, rd_v, prdata;
  logic              pready, pslverr, ir_valid, dm_rd_strobe, dm_wr_strobe;
  logic              restore_en, device_reset, irq_take;
  logic [3:0]        op_code = '0, phase_q, ph_prev, c_bs = '0, r_bs;
  logic [PC_W-1:0]   op_target = '0, pm_addr, irq_vector;
  logic [7:0]        op_data = '0, c_st = '0, c_wr = '0, r_st, r_wr;
  logic [15:0]       pm_rdata, ir;
  logic [19:0]       rs_v;
  int                n_errors = 0, checks_done = 0, rs_cnt = 0, dr_cnt = 0;

  cpsc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .instruction_holding_register(ir),
    .ir_valid(ir_valid), .phase_q(phase_q), .dm_rd_strobe(dm_rd_strobe),
    .dm_wr_strobe(dm_wr_strobe), .op_valid(op_valid), .op_code(op_code),
    .op_target(op_target), .op_data(op_data), .irq_take(irq_take),
    .irq_vector(irq_vector), .core_status(c_st),
    .core_working_register(c_wr), .core_bank_select_register(c_bs),
    .restore_en(restore_en), .restore_status(r_st),
    .restore_working_register(r_wr), .restore_bank_select_register(r_bs),
    .device_reset(device_reset));

  cpsc_far_model u_far (.pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .phase_q(phase_q), .irq_req(irq_req), .irq_take(irq_take),
    .irq_vector(irq_vector));

  always #12.5 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task por();
    presetn <= 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
  endtask : por

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    chk("pready", 32'(pready), 32'h0000_0001);
    rd_v = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, '0);
    chk(nm, rd_v, e);
  endtask : rd

  task wait_ph(input logic [3:0] p);
    int i;
    i = 0;
    do begin
      @(negedge pclk);
      i++;
    end while (phase_q !== p && i < 40);
    chk("phase wait", 32'(phase_q), 32'(p));
  endtask : wait_ph

  // An op is only taken at the edge ending a Q4 with a real instruction
  task op(input cpsc_op_t c, input logic [PC_W-1:0] t,
          input logic [7:0] d, input logic q);
    int i;
    i = 0;
    do begin
      wait_ph(4'b0100);
      i++;
    end while (ir_valid !== 1'b1 && i < 4);
    chk("op slot", 32'(ir_valid), 32'h0000_0001);
    @(posedge pclk);
    op_valid <= ~q;
    irq_req <= q;
    op_code <= c;
    op_target <= t;
    op_data <= d;
    @(posedge pclk);
    op_valid <= 0;
    irq_req <= 0;
  endtask : op

  task obs(input logic [PC_W-1:0] a, input logic v, input logic [15:0] w);
    wait_ph(4'b0010);
    chk("pm_addr", 32'(pm_addr), 32'(a));
    chk("ir_valid", 32'(ir_valid), 32'(v));
    if (v) begin
      chk("ir", 32'(ir), 32'(w));
    end
  endtask : obs

  task settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // ==========================================================
  // Monitors
  always @(negedge pclk) begin
    if (presetn !== 1'b1) begin
      ph_prev = '0;
      dr_prev = 0;
    end else begin
      if (dr_prev === 1'b1 || ph_prev === 4'h0)
        chk("restart", 32'(phase_q), 32'h0000_0001);
      else
        chk("phase", 32'(phase_q), 32'({ph_prev[2:0], ph_prev[3]}));
      chk("dm_rd", 32'(dm_rd_strobe), 32'(ir_valid && phase_q == 4'h2));
      chk("dm_wr", 32'(dm_wr_strobe), 32'(ir_valid && phase_q == 4'h8));
      ph_prev = phase_q;
      dr_prev = device_reset;
    end
  end

  always @(posedge pclk) begin
    if (restore_en === 1'b1) begin
      rs_cnt++;
      rs_v = {r_st, r_wr, r_bs};
    end
    if (device_reset === 1'b1)
      dr_cnt++;
  end

  initial begin
    #100_000;
    n_errors++;
    $display("watchdog expired");
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    por();
    rd(OFF_CONFIG, 32'h0000_0001, "cfg reset");
    rd(OFF_STACK, 32'h0000_0000, "stack reset");
    rd(8'h20, 32'h0000_0000, "unmapped");
    chk("pslverr", 32'(err), 32'h0000_0001);
    $display("reset test done");
    op(OP_BRANCH, 21'h0_0100, 8'h00, 1'b0);
    obs(21'h0_0100, 1'b0, '0);
    for (int k = 1; k < 4; k++) begin
      obs(21'(256 + 2 * k), 1'b1, {8'(127 + k), 8'(128 - k)});
    end
    apb(1'b1, OFF_PC_LATCH, 32'h0000_0123);
    op(OP_WRITE_PCL, '0, 8'h46, 1'b0);
    obs(21'h1_2346, 1'b0, '0);
    $display("flow test done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_TBL_PTR, 32'(256 + k));
      op(OP_TABLE_READ, '0, 8'h00, 1'b0);
      settle();
      settle();
      rd(OFF_TBL_LATCH, k ? 32'h0000_0080 : 32'h0000_007F, "table");
    end
    $display("table test done");
    {c_st, c_wr, c_bs} <= 20'h1_1223;
    op(OP_CALL_FAST, 21'h0_0200, 8'h00, 1'b0);
    {c_st, c_wr, c_bs} <= 20'h4_4556;
    op(OP_RETURN_FAST, 21'h0_0300, 8'h00, 1'b0);
    settle();
    chk("fast ret", 32'(rs_v), 32'h0001_1223);
    op(OP_NONE, '0, 8'h00, 1'b1);
    {c_st, c_wr, c_bs} <= 20'h7_7889;
    op(OP_NONE, '0, 8'h00, 1'b1);
    {c_st, c_wr, c_bs} <= 20'hA_ABBC;
    op(OP_RETURN_FROM_INTERRUPT_FAST, 21'h0_0400, 8'h00, 1'b0);
    settle();
    chk("fast return_from_interrupt", 32'(rs_v), 32'h0007_7889);
    op(OP_RETURN_FROM_INTERRUPT, 21'h0_0400, 8'h00, 1'b0);
    settle();
    chk("restores", 32'(rs_cnt), 32'h0000_0002);
    $display("shadow test done");
    apb(1'b1, OFF_CONFIG, 32'h0000_0000);
    apb(1'b1, OFF_STACK, 32'h0000_001E);
    op(OP_CALL, 21'h0_0500, 8'h00, 1'b0);
    rd(OFF_STACK, 32'h0000_009F, "full");
    op(OP_CALL, 21'h0_0500, 8'h00, 1'b0);
    rd(OFF_STACK, 32'h0000_009F, "full hold");
    chk("no reset", 32'(dr_cnt), 32'h0000_0000);
    apb(1'b1, OFF_STACK, 32'h0000_0000);
    rd(OFF_STACK, 32'h0000_0000, "clear");
    apb(1'b1, OFF_CONFIG, 32'h0000_0001);
    op(OP_RETURN, 21'h0_0600, 8'h00, 1'b0);
    settle();
    chk("unf reset", 32'(dr_cnt), 32'h0000_0001);
    rd(OFF_STACK, 32'h0000_0040, "unf kept");
    apb(1'b1, OFF_STACK, 32'h0000_005E);
    op(OP_CALL, 21'h0_0600, 8'h00, 1'b0);
    settle();
    chk("full reset", 32'(dr_cnt), 32'h0000_0002);
    rd(OFF_STACK, 32'h0000_00C0, "both kept");
    $display("stack test done");
    por();
    rd(OFF_STACK, 32'h0000_0000, "por flags");
    rd(OFF_CONFIG, 32'h0000_0001, "por cfg");
    $display("power-on test done");
    summarize();
  end
endmodule : tb_cpu_pipeline_stack_control
